// ### design/wdm_pkg.sv
// constants for the watchdog and group management interrupt block
//
// Function
// - timeout 1..255, units bit selects seconds/minutes
// - reload value zero disables, resets to zero
// - nonzero reload write restarts countdown
// - count zero halts, sets timeout status
// - host may set or clear status
// - keyboard, mouse, joystick activity individually enabled
// - enabled activity reloads count, clears status
// - interrupt request follows status on channel
// - force bit zeroes count, sets status
// - pin polarity and buffer type selectable
// - group interrupt ORs enabled status bits
// - pin driven only while enable2 bit7
// - enable2 bit6 routes group to IRQ2
// - enable2 bit5 routes group to wake
// - gpio status edge follows polarity, either-edge
// - gpio status cleared only by write-one
// - latched gpio status gated by enable
// - function status ignores writes; infrared read-clears
// - live function events gated by enable
// - sources: parallel, serial, floppy, midi, watchdog...
// - device interrupt status bit3, write-one clears
`default_nettype none
package wdm_pkg;
  localparam logic [7:0] ADDR_UNITS = 8'h52;
  localparam logic [7:0] ADDR_VAL   = 8'h53;
  localparam logic [7:0] ADDR_CFG   = 8'h54;
  localparam logic [7:0] ADDR_CTRL  = 8'h55;
  localparam logic [7:0] ADDR_STS1  = 8'h40;
  localparam logic [7:0] ADDR_STS2  = 8'h41;
  localparam logic [7:0] ADDR_STS3  = 8'h42;
  localparam logic [7:0] ADDR_STS5  = 8'h44;
  localparam logic [7:0] ADDR_EN1   = 8'h48;
  localparam logic [7:0] ADDR_EN5   = 8'h4c;
  localparam logic [7:0] ADDR_WAKE3 = 8'h50;
  localparam int UNITS_MIN_BIT  = 7;
  localparam int CTRL_STS_BIT   = 0;
  localparam int CTRL_FORCE_BIT = 2;
  localparam int CFG_KBD_BIT    = 0;
  localparam int CFG_MOUSE_BIT  = 1;
  localparam int CFG_JOY_BIT    = 2;
  localparam int CFG_CHAN_LSB   = 4;
  localparam int EN2_PIN_BIT    = 7;
  localparam int EN2_SERIRQ_BIT = 6;
  localparam int EN2_WAKE_BIT   = 5;
  localparam int WAKE3_DEV_BIT  = 3;
  localparam int GPIO_N         = 24;
  localparam logic [7:0] VAL_RST = 8'h00;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [14:0] TICKS_PER_SEC = 15'h7fff;
  localparam logic [5:0]  SEC_PER_MIN   = 6'h3b;
endpackage : wdm_pkg
`default_nettype wire

// ### design/wdm_watchdog_mgmt_int.sv
// watchdog timer with group management interrupt aggregation
`default_nettype none
module wdm_watchdog_mgmt_int (
  input  wire logic                      i_core_clk,
  input  wire logic                      i_reset,
  input  wire logic                      i_tick_32k,
  input  wire logic [7:0]                i_reg_addr,
  input  wire logic                      i_reg_wr,
  input  wire logic                      i_reg_rd,
  input  wire logic [7:0]                i_reg_wdata,
  output logic      [7:0]                o_reg_rdata,
  input  wire logic                      i_kbd_irq,
  input  wire logic                      i_mouse_irq,
  input  wire logic                      i_joy_access,
  input  wire logic [4:0]                i_sio_irq,
  input  wire logic                      i_ir_event,
  input  wire logic [wdm_pkg::GPIO_N-1:0] i_gpio_evt,
  input  wire logic [wdm_pkg::GPIO_N-1:0] i_gpio_invert,
  input  wire logic [wdm_pkg::GPIO_N-1:0] i_gpio_either_edge,
  input  wire logic                      i_mgmt_pin_sel,
  input  wire logic                      i_mgmt_pin_invert,
  input  wire logic                      i_mgmt_pin_push_pull,
  output logic                           o_mgmt_int_pin_o,
  output logic                           o_mgmt_int_pin_oe_n,
  output logic                           o_serirq_irq2,
  output logic                           o_device_int_status,
  output logic                           o_wdt_irq_req,
  output logic      [3:0]                o_wdt_irq_chan,
  output logic                           o_group_mgmt_int
);
  import wdm_pkg::*;

  logic [7:0]        units_q;
  logic [7:0]        val_q;
  logic [7:0]        cfg_q;
  logic [7:0]        cnt_q;
  logic [7:0]        cnt_d;
  logic              sts_q;
  logic              sts_d;
  logic [14:0]       pre_q;
  logic [5:0]        min_q;
  logic              kbd_prev_q;
  logic              mouse_prev_q;
  logic              ir_q;
  logic              dev_q;
  logic [4:0][7:0]   en_q;
  logic [23:0]       gsts_q;
  logic [23:0]       gprev_q;
  logic [7:0]        rdata_q;

  // ------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------
  wire logic a_units = i_reg_addr == ADDR_UNITS;
  wire logic a_val   = i_reg_addr == ADDR_VAL;
  wire logic a_cfg   = i_reg_addr == ADDR_CFG;
  wire logic a_ctrl  = i_reg_addr == ADDR_CTRL;
  wire logic a_sts1  = i_reg_addr == ADDR_STS1;
  wire logic a_sts2  = i_reg_addr == ADDR_STS2;
  wire logic a_wake  = i_reg_addr == ADDR_WAKE3;
  wire logic a_g = (i_reg_addr >= ADDR_STS3) && (i_reg_addr <= ADDR_STS5);
  wire logic a_en = (i_reg_addr >= ADDR_EN1) && (i_reg_addr <= ADDR_EN5);
  wire logic [7:0] g_off  = i_reg_addr - ADDR_STS3;
  wire logic [7:0] en_off = i_reg_addr - ADDR_EN1;
  wire logic [1:0] g_sel  = g_off[1:0];
  wire logic [2:0] en_sel = en_off[2:0];
  wire logic wr_val  = i_reg_wr && a_val;
  wire logic wr_ctrl = i_reg_wr && a_ctrl;
  wire logic wr_g    = i_reg_wr && a_g;
  wire logic wr_wake = i_reg_wr && a_wake;
  wire logic rd_sts2 = i_reg_rd && a_sts2;

  // ------------------------------------------------------------
  // watchdog counter
  // ------------------------------------------------------------
  wire logic kbd_rise   = i_kbd_irq & ~kbd_prev_q;
  wire logic mouse_rise = i_mouse_irq & ~mouse_prev_q;
  wire logic act = (cfg_q[CFG_KBD_BIT] & kbd_rise)
                 | (cfg_q[CFG_MOUSE_BIT] & mouse_rise)
                 | (cfg_q[CFG_JOY_BIT] & i_joy_access);
  wire logic force_to = wr_ctrl & i_reg_wdata[CTRL_FORCE_BIT];
  wire logic restart  = wr_val | act;
  wire logic sec_tick = i_tick_32k && (pre_q == TICKS_PER_SEC);
  wire logic min_mode = units_q[UNITS_MIN_BIT];
  wire logic unit_tick = sec_tick && (!min_mode || min_q == SEC_PER_MIN);
  wire logic dec = unit_tick && (cnt_q != 8'h00) && !restart && !force_to;
  wire logic tmo = dec && (cnt_q == 8'h01);

  // a zero reload leaves the counter parked at zero
  assign cnt_d = force_to ? 8'h00 :
                 wr_val   ? i_reg_wdata :
                 act      ? val_q :
                 dec      ? cnt_q - 8'h01 : cnt_q;
  // hardware sets win over a host clear in the same cycle
  assign sts_d = tmo | force_to |
                 (wr_ctrl ? i_reg_wdata[CTRL_STS_BIT] :
                  (act ? 1'b0 : sts_q));

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_q <= REG_RST;
      sts_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      sts_q <= sts_d;
    end
  end

  // prescaler restarts on reload so the first unit is a full one
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      pre_q <= 15'h0000;
      min_q <= 6'h00;
    end else if (restart) begin
      pre_q <= 15'h0000;
      min_q <= 6'h00;
    end else if (i_tick_32k) begin
      pre_q <= sec_tick ? 15'h0000 : pre_q + 15'h0001;
      if (sec_tick) begin
        min_q <= (min_q == SEC_PER_MIN) ? 6'h00 : min_q + 6'h01;
      end
    end
  end

  assign o_wdt_irq_chan = cfg_q[CFG_CHAN_LSB +: 4];
  assign o_wdt_irq_req  = (o_wdt_irq_chan != 4'h0) & sts_q;

  // ------------------------------------------------------------
  // host registers
  // ------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      units_q <= REG_RST;
      val_q   <= VAL_RST;
      cfg_q   <= REG_RST;
      en_q    <= '0;
    end else if (i_reg_wr) begin
      if (a_units) units_q <= i_reg_wdata;
      if (a_val)   val_q   <= i_reg_wdata;
      if (a_cfg)   cfg_q   <= i_reg_wdata;
      if (a_en)    en_q[en_sel] <= i_reg_wdata;
    end
  end

  // ------------------------------------------------------------
  // event status
  // ------------------------------------------------------------
  // function events are live levels except infrared, which latches until read, and the latched watchdog status; writes to them are ignored
  wire logic [7:0] sts1 = {3'h0, i_sio_irq};
  wire logic [7:0] sts2 = {4'h0, sts_q, i_kbd_irq,
                           i_mouse_irq, ir_q};
  wire logic [23:0] g_rise = i_gpio_evt & ~gprev_q;
  wire logic [23:0] g_fall = ~i_gpio_evt & gprev_q;
  wire logic [23:0] g_set =
      (i_gpio_either_edge & (g_rise | g_fall)) |
      (~i_gpio_either_edge & ~i_gpio_invert & g_rise) |
      (~i_gpio_either_edge & i_gpio_invert & g_fall);
  wire logic [23:0] g_wmask =
      wr_g ? (24'(i_reg_wdata) << {g_sel, 3'b000}) : 24'h000000;
  wire logic [23:0] g_en = {en_q[4], en_q[3], en_q[2]};

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      gsts_q       <= 24'h000000;
      gprev_q      <= 24'h000000;
      kbd_prev_q   <= 1'b0;
      mouse_prev_q <= 1'b0;
      ir_q         <= 1'b0;
      dev_q        <= 1'b0;
    end else begin
      gsts_q       <= g_set | (gsts_q & ~g_wmask);
      gprev_q      <= i_gpio_evt;
      kbd_prev_q   <= i_kbd_irq;
      mouse_prev_q <= i_mouse_irq;
      ir_q         <= i_ir_event | (ir_q & ~rd_sts2);
      dev_q        <= (o_group_mgmt_int & en_q[1][EN2_WAKE_BIT]) |
                      (dev_q & ~(wr_wake &
                                 i_reg_wdata[WAKE3_DEV_BIT]));
    end
  end

  // ------------------------------------------------------------
  // group interrupt and routing
  // ------------------------------------------------------------
  assign o_group_mgmt_int = (|(sts1 & en_q[0])) |
                            (|(sts2 & en_q[1])) |
                            (|(gsts_q & g_en));
  assign o_serirq_irq2 = o_group_mgmt_int &
                         en_q[1][EN2_SERIRQ_BIT];
  assign o_device_int_status = dev_q;

  // open drain only pulls the pin low, whatever the polarity; default active low
  wire logic pin_drive = i_mgmt_pin_sel & en_q[1][EN2_PIN_BIT];
  assign o_mgmt_int_pin_o = i_mgmt_pin_invert ? o_group_mgmt_int
                                              : ~o_group_mgmt_int;
  assign o_mgmt_int_pin_oe_n = ~(pin_drive &
      (i_mgmt_pin_push_pull | ~o_mgmt_int_pin_o));

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  wire logic [7:0] rd_mux =
      a_units ? units_q :
      a_val   ? val_q :
      a_cfg   ? cfg_q :
      a_ctrl  ? {7'h00, sts_q} :
      a_sts1  ? sts1 :
      a_sts2  ? sts2 :
      a_g     ? gsts_q[{g_sel, 3'b000} +: 8] :
      a_en    ? en_q[en_sel] :
      a_wake  ? {4'h0, dev_q, 3'h0} : 8'h00;

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      rdata_q <= 8'h00;
    end else if (i_reg_rd) begin
      rdata_q <= rd_mux;
    end
  end
  assign o_reg_rdata = rdata_q;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  chk_zero_stays_idle: assert property (
    (val_q == 8'h00 && cnt_q == 8'h00 && !wr_val && !force_to)
      |=> cnt_q == 8'h00) else $error("idle counter moved");
  chk_reload_write: assert property (
    (wr_val && !force_to) |=> cnt_q == $past(i_reg_wdata))
    else $error("reload write not loaded");
  chk_timeout_sets: assert property (
    (dec && cnt_q == 8'h01) |=> (cnt_q == 8'h00 && sts_q))
    else $error("timeout did not halt and flag");
  chk_host_status: assert property (
    (wr_ctrl && !tmo && !force_to)
      |=> sts_q == $past(i_reg_wdata[CTRL_STS_BIT]))
    else $error("host status write lost");
  chk_activity_reload: assert property (
    (act && !wr_val && !wr_ctrl) |=> (cnt_q == val_q && !sts_q))
    else $error("activity did not reload");
  chk_force_timeout: assert property (
    force_to |=> (cnt_q == 8'h00 && sts_q))
    else $error("force did not time out");
  chk_irq_follows: assert property (
    (o_wdt_irq_chan != 4'h0) |-> o_wdt_irq_req == sts_q)
    else $error("request does not follow status");
  chk_pin_gate: assert property (
    !o_mgmt_int_pin_oe_n |-> en_q[1][EN2_PIN_BIT])
    else $error("pin driven while disabled");
  chk_irq2_route: assert property (
    o_serirq_irq2 |-> (o_group_mgmt_int && en_q[1][EN2_SERIRQ_BIT]))
    else $error("irq2 slot without route");
  chk_gpio_w1c: assert property (
    !wr_g |=> (gsts_q & $past(gsts_q)) == $past(gsts_q))
    else $error("gpio status cleared without write");
  chk_dev_status: assert property (
    (o_group_mgmt_int && en_q[1][EN2_WAKE_BIT]) |=> dev_q)
    else $error("device status not set");
  chk_minute_units: assert property (
    (dec && min_mode) |-> min_q == SEC_PER_MIN)
    else $error("minute decrement early");

  // either-edge pins latch any change; others only the polarity edge
  wire logic [23:0] gpio_edge_chk =
      ((i_gpio_evt ^ gprev_q) & i_gpio_either_edge) |
      ((i_gpio_evt ^ gprev_q) & (i_gpio_evt ^ i_gpio_invert) &
       ~i_gpio_either_edge);

  chk_kbd_activity: assert property (
    (cfg_q[CFG_KBD_BIT] && kbd_rise && !wr_val && !wr_ctrl)
      |=> (cnt_q == val_q && !sts_q))
    else $error("keyboard activity did not reload");
  chk_events_off: assert property (
    (cfg_q[CFG_JOY_BIT:CFG_KBD_BIT] == 3'h0 && !wr_val && !force_to &&
     !unit_tick) |=> cnt_q == $past(cnt_q))
    else $error("counter moved without an event");
  chk_gpio_edge_set: assert property (
    (|gpio_edge_chk)
      |=> (gsts_q & $past(gpio_edge_chk)) == $past(gpio_edge_chk))
    else $error("gpio edge did not set status");
  chk_gpio_latched: assert property (
    (|(gsts_q & g_en)) |-> o_group_mgmt_int)
    else $error("latched gpio status not in group");
  chk_func_live: assert property (
    (|(i_sio_irq & en_q[0][4:0])) |-> o_group_mgmt_int)
    else $error("live function event not in group");
  chk_group_quiet: assert property (
    (en_q == '0) |-> !o_group_mgmt_int)
    else $error("group active with all enables clear");
  chk_ir_read_clear: assert property (
    (rd_sts2 && !i_ir_event) |=> !ir_q)
    else $error("infrared status survived read");
  chk_wake_route: assert property (
    $rose(dev_q) |-> ($past(o_group_mgmt_int) &&
                      $past(en_q[1][EN2_WAKE_BIT])))
    else $error("device status set without wake route");
  chk_open_drain: assert property (
    (!i_mgmt_pin_push_pull && !o_mgmt_int_pin_oe_n) |-> !o_mgmt_int_pin_o)
    else $error("open drain pin drove high");
  chk_pin_polarity: assert property (
    !o_mgmt_int_pin_oe_n
      |-> o_mgmt_int_pin_o == (o_group_mgmt_int ^ !i_mgmt_pin_invert))
    else $error("pin level against polarity");

  cov_timeout: cover property (tmo);
  cov_activity: cover property (act && sts_q);
  cov_pin_drive: cover property (!o_mgmt_int_pin_oe_n);
  cov_gpio_either: cover property (|(g_set & i_gpio_either_edge));
  cov_kbd_reload: cover property (cfg_q[CFG_KBD_BIT] && kbd_rise);
endmodule : wdm_watchdog_mgmt_int
`default_nettype wire

// ### dv/wdm_host_model.sv
// host side model: time base and activity sources for the watchdog
`default_nettype none
module wdm_host_model (
  input  wire logic       i_core_clk,
  input  wire logic [2:0] i_act,
  output logic            o_tick_32k,
  output logic            o_kbd_irq,
  output logic            o_mouse_irq,
  output logic            o_joy_access
);
  timeunit 1ns;
  timeprecision 1ps;
  // tick every clock so a second is 32768 clocks, keeps the run short
  always @(negedge i_core_clk) begin
    o_tick_32k   <= 1'b1;
    o_kbd_irq    <= i_act[0];
    o_mouse_irq  <= i_act[1];
    o_joy_access <= i_act[2] & ~o_joy_access;
  end
endmodule : wdm_host_model
`default_nettype wire

// ### dv/tb_watchdog_mgmt_interrupt.sv
// self-checking bench for the watchdog and group interrupt block
`default_nettype none
module tb_watchdog_mgmt_interrupt;
  timeunit 1ns;
  timeprecision 1ps;
  import wdm_pkg::*;
  logic        clk = 0, rst = 1, wr = 0, rd = 0, ir = 0;
  logic [7:0]  adr = 8'h00, wd = 8'h00, rdat, v;
  logic [4:0]  sio = 5'h00;
  logic [2:0]  act = 3'h0;
  logic [23:0] gev = 24'h0, ginv = 24'h2, gee = 24'h4;
  logic        psel = 0, pinv = 0, ppp = 0;
  logic        tick, kbd, mou, joy, po, poe, s2, dev, wreq, grp;
  logic [3:0]  wch;
  int          errors = 0, checked = 0;
  always #2 clk = ~clk;
  wdm_host_model u_wdm_host_model (.i_core_clk(clk), .i_act(act),
    .o_tick_32k(tick), .o_kbd_irq(kbd), .o_mouse_irq(mou),
    .o_joy_access(joy));
  wdm_watchdog_mgmt_int u_wdm_watchdog_mgmt_int (.i_core_clk(clk),
    .i_reset(rst), .i_tick_32k(tick), .i_reg_addr(adr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wd), .o_reg_rdata(rdat),
    .i_kbd_irq(kbd), .i_mouse_irq(mou), .i_joy_access(joy),
    .i_sio_irq(sio), .i_ir_event(ir), .i_gpio_evt(gev),
    .i_gpio_invert(ginv), .i_gpio_either_edge(gee),
    .i_mgmt_pin_sel(psel), .i_mgmt_pin_invert(pinv),
    .i_mgmt_pin_push_pull(ppp), .o_mgmt_int_pin_o(po),
    .o_mgmt_int_pin_oe_n(poe), .o_serirq_irq2(s2),
    .o_device_int_status(dev), .o_wdt_irq_req(wreq),
    .o_wdt_irq_chan(wch), .o_group_mgmt_int(grp));
  task automatic report_and_stop;
    if (errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    adr = a;
    wd  = d;
    wr  = 1'b1;
    @(negedge clk);
    wr  = 1'b0;
  endtask : wrr
  task automatic rdr(input logic [7:0] a);
    @(negedge clk);
    adr = a;
    rd  = 1'b1;
    @(negedge clk);
    rd  = 1'b0;
    @(negedge clk);
    v   = rdat;
  endtask : rdr
  task automatic t_force;
    rdr(ADDR_VAL);
    chk(v, VAL_RST);
    wrr(ADDR_CFG, 8'h10);
    wrr(ADDR_CTRL, 8'h04);
    rdr(ADDR_CTRL);
    chk(v, 8'h01);
    chk({3'h0, wreq, wch}, 8'h11);
    wrr(ADDR_CTRL, 8'h00);
    rdr(ADDR_CTRL);
    chk(v, 8'h00);
    chk({7'h0, wreq}, 8'h00);
    wrr(ADDR_CTRL, 8'h01);
    rdr(ADDR_CTRL);
    chk(v, 8'h01);
  endtask : t_force
  task automatic t_activity;
    wrr(ADDR_CFG, 8'h05);
    wrr(ADDR_VAL, 8'h01);
    wrr(ADDR_CTRL, 8'h04);
    act <= 3'h2;
    rdr(ADDR_CTRL);
    chk(v, 8'h01);
    act <= 3'h4;
    @(negedge clk);
    act <= 3'h0;
    rdr(ADDR_CTRL);
    chk(v, 8'h00);
    // one unit is 32768 ticks after the reload
    repeat (32700) @(negedge clk);
    rdr(ADDR_CTRL);
    chk(v, 8'h00);
    repeat (100) @(negedge clk);
    rdr(ADDR_CTRL);
    chk(v, 8'h01);
  endtask : t_activity
  task automatic t_group;
    psel = 1'b1;
    wrr(ADDR_EN1, 8'h01);
    wrr(ADDR_EN1 + 8'h01, 8'he0);
    sio = 5'h01;
    repeat (2) @(negedge clk);
    chk({4'h0, grp, s2, po, poe}, 8'h0c);
    rdr(ADDR_WAKE3);
    chk(v, 8'h08);
    chk({7'h0, dev}, 8'h01);
    pinv = 1'b1;
    ppp  = 1'b1;
    @(negedge clk);
    chk({6'h0, po, poe}, 8'h02);
    wrr(ADDR_EN1, 8'h00);
    chk({7'h0, grp}, 8'h00);
    sio = 5'h00;
    wrr(ADDR_WAKE3, 8'h08);
    rdr(ADDR_WAKE3);
    chk(v, 8'h00);
  endtask : t_group
  task automatic t_gpio;
    wrr(ADDR_EN1 + 8'h02, 8'h07);
    gev = 24'h7;
    rdr(ADDR_STS3);
    chk(v, 8'h05);
    chk({7'h0, grp}, 8'h01);
    gev = 24'h0;
    rdr(ADDR_STS3);
    chk(v, 8'h07);
    chk({7'h0, grp}, 8'h01);
    wrr(ADDR_STS3, 8'h00);
    rdr(ADDR_STS3);
    chk(v, 8'h07);
    wrr(ADDR_STS3, 8'h07);
    rdr(ADDR_STS3);
    chk(v, 8'h00);
    chk({7'h0, grp}, 8'h00);
  endtask : t_gpio
  task automatic t_ir;
    @(negedge clk);
    ir = 1'b1;
    @(negedge clk);
    ir = 1'b0;
    rdr(ADDR_STS2);
    chk(v & 8'h01, 8'h01);
    rdr(ADDR_STS2);
    chk(v & 8'h01, 8'h00);
    sio = 5'h04;
    wrr(ADDR_STS1, 8'hff);
    rdr(ADDR_STS1);
    chk(v, 8'h04);
    sio = 5'h00;
    rdr(ADDR_STS1);
    chk(v, 8'h00);
    rdr(8'h7f);
    chk(v, 8'h00);
  endtask : t_ir
  task automatic t_minute;
    wrr(ADDR_UNITS, 8'h80);
    rdr(ADDR_UNITS);
    chk(v, 8'h80);
    wrr(ADDR_CTRL, 8'h00);
    wrr(ADDR_VAL, 8'h01);
    // past one second of ticks, still short of a minute unit
    repeat (32800) @(negedge clk);
    rdr(ADDR_CTRL);
    chk(v, 8'h00);
    wrr(ADDR_CTRL, 8'h04);
    act <= 3'h1;
    @(negedge clk);
    act <= 3'h0;
    rdr(ADDR_CTRL);
    chk(v, 8'h00);
  endtask : t_minute
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    t_force();
    t_activity();
    t_group();
    t_gpio();
    t_ir();
    t_minute();
    report_and_stop();
  end
  // about one and a half times the expected run
  initial begin
    #400000;
    errors++;
    report_and_stop();
  end
endmodule : tb_watchdog_mgmt_interrupt
`default_nettype wire
